/* File: hw/bft_pkg.sv */
// Constants, types and register map of the breaker failure timing block
// Function
// RULE1 - Current-only mode starts both delays on current
// RULE2 - Current-only: outputs assert when delays elapse
// RULE3 - Current-and-contact: counters halt until contact driven
// RULE4 - Current-and-contact: reset on current or contact loss
// RULE5 - Current-or-contact: either condition starts counting
// RULE6 - Current-or-contact: reset only when both released
// RULE7 - Retrip disabled: only failure counter runs
// RULE8 - Signals-only: binary input starts failure counter
// RULE9 - ON/OFF events for eight signals, selectable
// RULE10 - Resettable counts of retrip, failure, start, block
// RULE11 - Circular log of last twelve ON records
// RULE12 - Record holds event, currents, remaining times, group
// RULE13 - Retrip enable gates second coil output
// RULE14 - Delays in 5 ms steps, common pickup
// RULE15 - Block at pickup flags blocked, resets start
// RULE16 - Counters advance per tick, assert on reach
package bft_pkg;
    // Register byte offsets
    localparam logic [7:0] BFT_REG_CTRL = 8'h00;
    localparam logic [7:0] BFT_REG_RETR_DLY = 8'h04;
    localparam logic [7:0] BFT_REG_FAIL_DLY = 8'h08;
    localparam logic [7:0] BFT_REG_STATUS = 8'h0C;
    localparam logic [7:0] BFT_REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] BFT_REG_IRQ_MASK = 8'h14;
    localparam logic [7:0] BFT_REG_EVT_SEL = 8'h18;
    localparam logic [7:0] BFT_REG_CNT_RETR = 8'h1C;
    localparam logic [7:0] BFT_REG_CNT_FAIL = 8'h20;
    localparam logic [7:0] BFT_REG_CNT_START = 8'h24;
    localparam logic [7:0] BFT_REG_CNT_BLK = 8'h28;
    localparam logic [7:0] BFT_REG_LOG_IDX = 8'h2C;
    localparam logic [7:0] BFT_REG_LOG_W0 = 8'h30;
    localparam logic [7:0] BFT_REG_LOG_W1 = 8'h34;
    localparam logic [7:0] BFT_REG_LOG_W2 = 8'h38;
    localparam logic [7:0] BFT_REG_LOG_W3 = 8'h3C;
    localparam logic [7:0] BFT_REG_TIME = 8'h40;
    // Control field positions
    localparam int BFT_CTRL_MODE_LSB = 0;
    localparam int BFT_CTRL_RETR_EN = 4;
    localparam int BFT_CTRL_CNT_CLR = 5;
    localparam logic [31:0] BFT_CTRL_RESET = 32'h0000_0010;
    // Timing: tick period and delay steps
    localparam int BFT_CLK_HZ = 20_000_000;
    localparam int BFT_TICK_US = 5000;
    localparam int BFT_TICK_CYC = BFT_CLK_HZ / 1_000_000 * BFT_TICK_US;
    localparam int BFT_MS_CYC = BFT_CLK_HZ / 1000;
    localparam int BFT_STEP_MS = 5;
    localparam int BFT_RETR_DEF_MS = 100;
    localparam int BFT_FAIL_DEF_MS = 200;
    localparam logic [19:0] BFT_RETR_DEF = 20'(BFT_RETR_DEF_MS / BFT_STEP_MS);
    localparam logic [19:0] BFT_FAIL_DEF = 20'(BFT_FAIL_DEF_MS / BFT_STEP_MS);
    localparam int BFT_LOG_DEPTH = 12;
    localparam int BFT_NEVT = 8;
    // Criterion modes
    typedef enum logic [3:0] {
        BFT_M_CUR = 4'h0,
        BFT_M_CUR_AND_DO = 4'h1,
        BFT_M_CUR_OR_DO = 4'h2,
        BFT_M_SIG = 4'h3
    } bft_mode_t;
    // Event indices, ON bit in the event word
    localparam int BFT_E_START = 0;
    localparam int BFT_E_RETR = 1;
    localparam int BFT_E_FAIL = 2;
    localparam int BFT_E_BLOCK = 3;
    localparam int BFT_E_DO = 4;
    localparam int BFT_E_SIG = 5;
    localparam int BFT_E_PH = 6;
    localparam int BFT_E_RES = 7;
    // One log record
    typedef struct packed {
        logic [31:0] stamp_ms;
        logic [3:0] event_id;
        logic [15:0] max_phase;
        logic [15:0] residual;
        logic [19:0] retr_left;
        logic [19:0] fail_left;
        logic [2:0] group;
    } bft_rec_t;
    // Measurement inputs
    typedef struct packed {
        logic [15:0] max_phase;
        logic [15:0] residual;
        logic phase_over;
        logic residual_over;
        logic [2:0] group;
    } bft_meas_t;
endpackage

/* File: hw/bft_delay.sv */
// One delay counter with start, halt and reset
`timescale 1ns/1ps
module bft_delay
    import bft_pkg::*;
#(
    parameter int W = 20
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input wire logic run,
    input wire logic hold,
    input wire logic [W-1:0] delay,
    output logic done,
    output logic [W-1:0] left
);
    initial begin
        if (W < 2) begin
            $error("bft_delay width too small");
        end
    end
    logic [W-1:0] cnt_q;

    // RULE16 tick count and reach
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else if (tick && !hold && cnt_q < delay) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
    assign done = run && (cnt_q >= delay) && !hold;
    assign left = (cnt_q >= delay) ? '0 : W'(delay - cnt_q);
endmodule

/* File: hw/bft_top.sv */
// Breaker failure timing block with Wishbone register slave
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module bft_top
    import bft_pkg::*;
#(
    parameter int TICK_CYC = BFT_TICK_CYC,
    parameter int MS_CYC = BFT_MS_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire bft_meas_t meas,
    input wire logic contact_in,
    input wire logic signal_in,
    input wire logic block_in,
    output logic second_coil_trip,
    output logic breaker_failure_output,
    output logic irq
);
    initial begin
        if (TICK_CYC < 1 || MS_CYC < 1) begin
            $error("bft_top tick counts must be positive");
        end
    end

    ////////////////////////////////////////////////////////////////
    // Input synchronisers for pins
    logic [2:0] pin_s1_q; // First stage, read by second only
    logic [2:0] pin_s2_q; // Stable pin levels
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {block_in, signal_in, contact_in};
            pin_s2_q <= pin_s1_q;
        end
    end
    // Pin levels
    logic contact, signal_act, blk;
    assign contact = pin_s2_q[0];
    assign signal_act = pin_s2_q[1];
    assign blk = pin_s2_q[2];

    ////////////////////////////////////////////////////////////////
    // Tick and millisecond time base
    logic [31:0] tick_cnt_q; // Cycles to next tick
    logic [31:0] ms_cnt_q; // Cycles to next millisecond
    logic [31:0] stamp_q; // Free millisecond stamp
    logic tick_q; // One-cycle processing tick
    // Tick paces delays
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end
    // Millisecond stamp for records
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ms_cnt_q <= '0;
            stamp_q <= '0;
        end else if (ms_cnt_q == 32'(MS_CYC - 1)) begin
            ms_cnt_q <= '0;
            stamp_q <= stamp_q + 32'h0000_0001;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Control registers
    logic [31:0] ctrl_q; // Mode, retrip enable
    logic [19:0] retr_dly_q; // Retrip delay in ticks
    logic [19:0] fail_dly_q; // Failure delay in ticks
    logic [BFT_NEVT-1:0] irq_stat_q, irq_mask_q;
    logic [2*BFT_NEVT-1:0] evt_sel_q; // ON bits low half, OFF high half
    logic [3:0] log_idx_q; // Record to read
    logic wr, rd_req;
    // Write on ack edge
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    bft_mode_t mode;
    assign mode = bft_mode_t'(ctrl_q[BFT_CTRL_MODE_LSB +: 4]);
    logic retr_en;
    assign retr_en = ctrl_q[BFT_CTRL_RETR_EN];

    // Byte-lane write merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        // Enabled lanes only
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Writable setting registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= BFT_CTRL_RESET;
            retr_dly_q <= BFT_RETR_DEF;
            fail_dly_q <= BFT_FAIL_DEF;
            irq_mask_q <= '0;
            evt_sel_q <= '1;
            log_idx_q <= '0;
        end else if (wr) begin
            unique case (wb_adr_i)
                BFT_REG_CTRL: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i);
                BFT_REG_RETR_DLY: retr_dly_q <= 20'(merge(32'(retr_dly_q), wb_dat_i, wb_sel_i));
                BFT_REG_FAIL_DLY: fail_dly_q <= 20'(merge(32'(fail_dly_q), wb_dat_i, wb_sel_i));
                BFT_REG_IRQ_MASK: irq_mask_q <= wb_dat_i[BFT_NEVT-1:0];
                BFT_REG_EVT_SEL: evt_sel_q <= wb_dat_i[2*BFT_NEVT-1:0];
                BFT_REG_LOG_IDX: log_idx_q <= wb_dat_i[3:0];
                // Ignored
                default: ;
            endcase
        end else begin
            // One-cycle clear
            ctrl_q[BFT_CTRL_CNT_CLR] <= 1'b0;
        end
    end
    logic cnt_clr;
    assign cnt_clr = ctrl_q[BFT_CTRL_CNT_CLR];

    ////////////////////////////////////////////////////////////////
    // Pickup decision per criterion
    logic cur_over, pickup, hold, start_q, blocked_q;
    assign cur_over = meas.phase_over || meas.residual_over;
    always_comb begin
        pickup = 1'b0;
        hold = 1'b0;
        unique case (mode)
            // RULE1 current alone starts
            BFT_M_CUR: pickup = cur_over;
            // RULE3 halt until contact
            // RULE4 reset on either loss
            BFT_M_CUR_AND_DO: begin
                pickup = cur_over;
                hold = !contact;
            end
            // RULE5 either starts count
            // RULE6 release needs both
            BFT_M_CUR_OR_DO: pickup = cur_over || contact;
            // RULE8 binary input start
            BFT_M_SIG: pickup = signal_act;
            // Illegal codes
            default: pickup = 1'b0;
        endcase
    end
    logic contact_seen_q; // Contact has been driven during this start
    // RULE4 contact loss resets
    logic hold_eff;
    assign hold_eff = hold && !(start_q && mode == BFT_M_CUR_AND_DO && contact_seen_q);
    // Contact memory
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            contact_seen_q <= 1'b0;
        end else if (!pickup) begin
            contact_seen_q <= 1'b0;
        end else if (contact) begin
            contact_seen_q <= 1'b1;
        end
    end
    logic drop; // Contact released after it was driven
    assign drop = mode == BFT_M_CUR_AND_DO && contact_seen_q && !contact;

    // RULE15 block at pickup
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_q <= 1'b0;
            blocked_q <= 1'b0;
        end else begin
            // Block or drop clears
            start_q <= pickup && !blk && !drop;
            blocked_q <= pickup && blk;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Delay counters
    logic retr_done, fail_done;
    logic [19:0] retr_left, fail_left;
    // Idle in signal mode
    // RULE7 retrip counter gated
    // RULE14 common pickup starts both
    bft_delay #(.W(20)) u_retr (
        .mclk(mclk), .rst(rst), .tick(tick_q), .run(start_q && retr_en && mode != BFT_M_SIG),
        .hold(hold_eff), .delay(retr_dly_q), .done(retr_done), .left(retr_left)
    );
    bft_delay #(.W(20)) u_fail (
        .mclk(mclk), .rst(rst), .tick(tick_q), .run(start_q), .hold(hold_eff),
        .delay(fail_dly_q), .done(fail_done), .left(fail_left)
    );
    // RULE2 outputs on elapse
    // RULE13 retrip enable gate
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            second_coil_trip <= 1'b0;
            breaker_failure_output <= 1'b0;
        end else begin
            second_coil_trip <= retr_done && retr_en;
            breaker_failure_output <= fail_done;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Event detection
    logic [BFT_NEVT-1:0] lvl, lvl_q, ev_on, ev_off;
    assign lvl = {meas.residual_over, meas.phase_over, signal_act, contact, blocked_q,
                  breaker_failure_output, second_coil_trip, start_q};
    // Previous levels
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= lvl;
        end
    end
    // RULE9 selectable ON and OFF
    assign ev_on = lvl & ~lvl_q & evt_sel_q[BFT_NEVT-1:0];
    assign ev_off = ~lvl & lvl_q & evt_sel_q[2*BFT_NEVT-1:BFT_NEVT];

    // Sticky status, set wins over clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_stat_q <= '0;
        end else if (wr && wb_adr_i == BFT_REG_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wb_dat_i[BFT_NEVT-1:0]) | ev_on | ev_off;
        end else begin
            irq_stat_q <= irq_stat_q | ev_on | ev_off;
        end
    end
    // Level interrupt
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////
    // RULE10 cumulative counts
    logic [31:0] cnt_q [4];
    logic [3:0] cnt_ev;
    assign cnt_ev = {lvl[BFT_E_BLOCK] & ~lvl_q[BFT_E_BLOCK], lvl[BFT_E_START] & ~lvl_q[BFT_E_START],
                     lvl[BFT_E_FAIL] & ~lvl_q[BFT_E_FAIL], lvl[BFT_E_RETR] & ~lvl_q[BFT_E_RETR]};
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) cnt_q[i] <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                // Clear plus event gives one
                if (cnt_ev[i]) cnt_q[i] <= cnt_clr ? 32'h0000_0001 : cnt_q[i] + 32'h0000_0001;
                else if (cnt_clr) cnt_q[i] <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // RULE11 circular record log
    bft_rec_t log_q [BFT_LOG_DEPTH];
    logic [3:0] wptr_q;
    logic [3:0] first_on;
    // Lowest rising index
    always_comb begin
        first_on = '0;
        for (int i = BFT_NEVT - 1; i >= 0; i--) begin
            if (lvl[i] && !lvl_q[i]) first_on = 4'(i);
        end
    end
    // RULE12 record contents
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wptr_q <= '0;
            for (int i = 0; i < BFT_LOG_DEPTH; i++) log_q[i] <= '0;
        end else if (|(lvl & ~lvl_q)) begin
            log_q[wptr_q] <= '{stamp_q, first_on, meas.max_phase, meas.residual,
                               retr_left, fail_left, meas.group};
            // Wrap at the end
            wptr_q <= (wptr_q == 4'(BFT_LOG_DEPTH - 1)) ? 4'h0 : wptr_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Wishbone read and ack
    bft_rec_t rec;
    // Bad index reads record 0
    assign rec = log_q[(log_idx_q < 4'(BFT_LOG_DEPTH)) ? log_idx_q : 4'h0];
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            // One-cycle answer
            wb_ack_o <= rd_req;
            wb_dat_o <= '0;
            if (rd_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    BFT_REG_CTRL: wb_dat_o <= ctrl_q;
                    BFT_REG_RETR_DLY: wb_dat_o <= 32'(retr_dly_q);
                    BFT_REG_FAIL_DLY: wb_dat_o <= 32'(fail_dly_q);
                    BFT_REG_STATUS: wb_dat_o <= 32'({wptr_q, lvl});
                    BFT_REG_IRQ_STAT: wb_dat_o <= 32'(irq_stat_q);
                    BFT_REG_IRQ_MASK: wb_dat_o <= 32'(irq_mask_q);
                    BFT_REG_EVT_SEL: wb_dat_o <= 32'(evt_sel_q);
                    BFT_REG_CNT_RETR: wb_dat_o <= cnt_q[0];
                    BFT_REG_CNT_FAIL: wb_dat_o <= cnt_q[1];
                    BFT_REG_CNT_START: wb_dat_o <= cnt_q[2];
                    BFT_REG_CNT_BLK: wb_dat_o <= cnt_q[3];
                    BFT_REG_LOG_IDX: wb_dat_o <= 32'(log_idx_q);
                    BFT_REG_LOG_W0: wb_dat_o <= rec.stamp_ms;
                    BFT_REG_LOG_W1: wb_dat_o <= {rec.max_phase, rec.residual};
                    BFT_REG_LOG_W2: wb_dat_o <= {rec.event_id, rec.group, 5'h00, rec.retr_left};
                    BFT_REG_LOG_W3: wb_dat_o <= 32'(rec.fail_left);
                    BFT_REG_TIME: wb_dat_o <= stamp_q;
                    // Unmapped reads zero
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end
endmodule

/* File: tb/bft_top_asserts.sv */
// Concurrent checks on the ports of the breaker failure timing block
`timescale 1ns/1ps
module bft_top_asserts
    import bft_pkg::*;
#(
    parameter int TICK_CYC = BFT_TICK_CYC,
    parameter int MS_CYC = BFT_MS_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire bft_meas_t meas,
    input wire logic contact_in,
    input wire logic signal_in,
    input wire logic block_in,
    input wire logic second_coil_trip,
    input wire logic breaker_failure_output,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    logic [31:0] ctrl_q; // Shadow of the control register
    logic [19:0] fail_dly_q; // Shadow of the failure delay
    int idle_q, busy_q, cur_q, nocon_q; // Run lengths of input conditions
    logic wr_ack, retr_off, cause, cur;
    int fail_lim, fail_lo;
    assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign retr_off = !ctrl_q[BFT_CTRL_RETR_EN];
    assign cause = meas.phase_over || meas.residual_over || contact_in || signal_in;
    assign cur = (meas.phase_over || meas.residual_over) && !block_in;
    assign fail_lim = (int'(fail_dly_q) + 1) * TICK_CYC + 4;
    assign fail_lo = (int'(fail_dly_q) - 1) * TICK_CYC;
    // Saturating run-length step
    function automatic int step(input int c, input logic go);
        return go ? ((c < 100000) ? c + 1 : c) : 0;
    endfunction
    // Follow register writes at the acking edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_q <= BFT_CTRL_RESET;
            fail_dly_q <= BFT_FAIL_DEF;
        end else if (wr_ack && wb_adr_i == BFT_REG_CTRL) begin
            ctrl_q <= wb_dat_i;
        end else if (wr_ack && wb_adr_i == BFT_REG_FAIL_DLY) begin
            fail_dly_q <= wb_dat_i[19:0];
        end
    end
    // Count how long each condition has held
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            idle_q <= 0;
            busy_q <= 0;
            cur_q <= 0;
            nocon_q <= 0;
        end else begin
            idle_q <= step(idle_q, !cause);
            busy_q <= step(busy_q, cause);
            cur_q <= step(cur_q, cur);
            nocon_q <= step(nocon_q, !contact_in);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_after_take: assert property (s_take |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_reset_quiet: assert property ($fell(rst) |-> !irq && !second_coil_trip
        && !breaker_failure_output) else $error("output high after reset");
    a_quiet_idle: assert property (
        idle_q >= 8 |-> !second_coil_trip && !breaker_failure_output)
        else $error("output held without pickup");
    a_fail_not_early: assert property (
        $rose(breaker_failure_output) |-> busy_q > fail_lo)
        else $error("failure output too early");
    a_fail_not_late: assert property (
        ctrl_q[3:0] == BFT_M_CUR && cur_q == fail_lim |-> breaker_failure_output)
        else $error("failure output late");
    a_retrip_off: assert property (
        $past(retr_off, 4) && retr_off |-> !second_coil_trip)
        else $error("retrip while disabled");
    a_halt_no_contact: assert property (
        ctrl_q[3:0] == BFT_M_CUR_AND_DO && nocon_q >= 8 |-> !second_coil_trip
        && !breaker_failure_output) else $error("ran without contact");
endmodule
bind bft_top bft_top_asserts #(.TICK_CYC(TICK_CYC), .MS_CYC(MS_CYC)) bft_top_asserts_inst (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .meas(meas), .contact_in(contact_in), .signal_in(signal_in),
    .block_in(block_in), .second_coil_trip(second_coil_trip),
    .breaker_failure_output(breaker_failure_output), .irq(irq));

/* File: tb/tb_top.sv */
// Self-checking bench for the breaker failure timing block
`timescale 1ns/1ps
module tb_top;
    import bft_pkg::*;
    localparam int TICK = 10; // Shortened tick
    localparam int LIMIT = 20000; // Timeout in cycles
    logic mclk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, ia, ib;
    logic contact_in, signal_in, block_in, second_coil_trip, breaker_failure_output;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    bft_meas_t meas;
    int num_errors, comparisons, cycles, seed, m_retr, m_fail; // Counts model
    bft_top #(.TICK_CYC(TICK), .MS_CYC(4)) bft_top_inst (.mclk(mclk), .rst(rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .meas(meas), .contact_in(contact_in), .signal_in(signal_in), .block_in(block_in),
        .second_coil_trip(second_coil_trip), .breaker_failure_output(breaker_failure_output),
        .irq(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Cut a hang short
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            give_verdict();
        end
    end
    // Closing report
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Compare one value
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // One classic Wishbone cycle, read data lands in rd
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Apply inputs {block, signal, contact, residual, phase} for some ticks
    task automatic drive(input int v, input int ticks);
        @(posedge mclk);
        meas.phase_over <= v[0];
        meas.residual_over <= v[1];
        contact_in <= v[2];
        signal_in <= v[3];
        block_in <= v[4];
        meas.max_phase <= 16'($random(seed));
        meas.residual <= 16'($random(seed));
        meas.group <= 3'($random(seed));
        repeat (ticks * TICK - 1) @(posedge mclk);
    endtask
    // Three input phases, then outputs compared and released
    task automatic scen(input int mode, input int en, input int v0, input int t0, input int v1,
        input int t1, input int v2, input int t2, input int esc, input int ebf);
        wb(1'b1, BFT_REG_CTRL, 32'(mode) | (32'(en) << BFT_CTRL_RETR_EN));
        drive(v0, t0);
        drive(v1, t1);
        drive(v2, t2);
        check("second_coil_trip", 32'(second_coil_trip), 32'(esc));
        check("breaker_failure_output", 32'(breaker_failure_output), 32'(ebf));
        m_retr += esc;
        m_fail += ebf;
        drive(0, 1);
        check("released", 32'({second_coil_trip, breaker_failure_output}), 32'h0);
        $display("case done mode %0d inputs %0d", mode, v1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {seed, num_errors, comparisons, cycles, m_retr, m_fail} = {32'd9, 160'd0};
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {contact_in, signal_in, block_in, meas} = '0;
        wb_sel_i = 4'hF;
        rst = 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        wb(1'b0, BFT_REG_CTRL, 32'h0);
        check("ctrl_reset", rd, BFT_CTRL_RESET);
        wb(1'b0, BFT_REG_RETR_DLY, 32'h0);
        check("retr_reset", rd, 32'(BFT_RETR_DEF));
        wb(1'b0, BFT_REG_FAIL_DLY, 32'h0);
        check("fail_reset", rd, 32'(BFT_FAIL_DEF));
        wb(1'b0, BFT_REG_EVT_SEL, 32'h0);
        check("evt_sel_reset", rd, 32'h0000FFFF);
        wb(1'b1, 8'hF0, 32'hFFFFFFFF);
        wb(1'b0, 8'hF0, 32'h0);
        check("unmapped", rd, 32'h0);
        wb(1'b1, BFT_REG_RETR_DLY, 32'h3);
        wb(1'b1, BFT_REG_FAIL_DLY, 32'h5);
        wb(1'b1, BFT_REG_IRQ_STAT, 32'hFF);
        scen(BFT_M_CUR, 1, 1, 4, 1, 2, 1, 2, 1, 1);
        wb(1'b0, BFT_REG_IRQ_STAT, 32'h0);
        check("irq_stat", rd & 32'h47, 32'h47);
        wb(1'b1, BFT_REG_IRQ_MASK, 32'h00);
        repeat (3) @(posedge mclk);
        ia = irq;
        wb(1'b1, BFT_REG_IRQ_MASK, 32'hFF);
        repeat (3) @(posedge mclk);
        ib = irq;
        check("irq_mask", 32'(ia ^ ib), 32'h1);
        wb(1'b1, BFT_REG_IRQ_STAT, 32'hFF);
        wb(1'b0, BFT_REG_IRQ_STAT, 32'h0);
        check("irq_clear", {rd[31:1], irq}, 32'h0);
        scen(BFT_M_CUR, 1, 2, 2, 2, 1, 2, 1, 1, 0);
        scen(BFT_M_CUR_AND_DO, 1, 1, 4, 1, 2, 1, 2, 0, 0);
        scen(BFT_M_CUR_AND_DO, 1, 1, 1, 5, 4, 5, 3, 1, 1);
        scen(BFT_M_CUR_AND_DO, 1, 5, 2, 1, 1, 5, 4, 1, 0);
        scen(BFT_M_CUR_OR_DO, 1, 4, 4, 4, 2, 4, 2, 1, 1);
        scen(BFT_M_CUR_OR_DO, 1, 1, 3, 5, 1, 4, 3, 1, 1);
        scen(BFT_M_CUR, 0, 1, 4, 1, 2, 1, 2, 0, 1);
        wb(1'b1, BFT_REG_EVT_SEL, 32'h0);
        wb(1'b1, BFT_REG_IRQ_STAT, 32'hFF);
        scen(BFT_M_SIG, 1, 8, 4, 8, 2, 8, 2, 0, 1);
        wb(1'b0, BFT_REG_IRQ_STAT, 32'h0);
        check("evt_none", rd & 32'hFF, 32'h0);
        wb(1'b1, BFT_REG_EVT_SEL, 32'h0000FFFF);
        scen(BFT_M_CUR, 1, 16, 1, 17, 7, 17, 1, 0, 0);
        wb(1'b0, BFT_REG_CNT_RETR, 32'h0);
        check("cnt_retr", rd, 32'(m_retr));
        wb(1'b0, BFT_REG_CNT_FAIL, 32'h0);
        check("cnt_fail", rd, 32'(m_fail));
        wb(1'b0, BFT_REG_CNT_START, 32'h0);
        check("cnt_start", rd, 32'hA);
        wb(1'b0, BFT_REG_CNT_BLK, 32'h0);
        check("cnt_blk", rd, 32'h1);
        wb(1'b1, BFT_REG_CTRL, 32'h00000030);
        wb(1'b0, BFT_REG_CNT_FAIL, 32'h0);
        check("cnt_clear", rd, 32'h0);
        give_verdict();
    end
endmodule
